// ===== rtl/cmo_pkg.sv
// Shared types and constants for the user-mapped cache maintenance unit.
// Assumes a 32-bit core with a single-cycle instruction issue handshake.
package cmo_pkg;

	localparam int XLEN           = 32;
	localparam int OFFS_W         = 9;
	localparam int OFFS_LSB       = 7;
	localparam int BASE_LSB       = 21;
	localparam int OP_LSB         = 18;
	localparam int CSEL_LSB       = 16;
	localparam int EVA_ON         = 1;

	// Target cache select, instruction bits [17:16]
	localparam logic [1:0] CSEL_PRI_I = 2'h0;
	localparam logic [1:0] CSEL_PRI_D = 2'h1;
	localparam logic [1:0] CSEL_TER   = 2'h2;
	localparam logic [1:0] CSEL_SEC   = 2'h3;

	// Operation codes, instruction bits [20:18]
	localparam logic [2:0] OP_IDX_INV    = 3'h0;
	localparam logic [2:0] OP_IDX_LD_TAG = 3'h1;
	localparam logic [2:0] OP_IDX_ST_TAG = 3'h2;
	localparam logic [2:0] OP_IMPL_DEP   = 3'h3;
	localparam logic [2:0] OP_HIT_INV    = 3'h4;
	localparam logic [2:0] OP_HIT_WB_INV = 3'h5;
	localparam logic [2:0] OP_HIT_WB     = 3'h6;
	localparam logic [2:0] OP_FETCH_LOCK = 3'h7;

	// Exception codes reported back to the pipeline
	localparam logic [3:0] EXC_NONE      = 4'h0;
	localparam logic [3:0] EXC_CPU       = 4'h1;
	localparam logic [3:0] EXC_TLB_REFILL= 4'h2;
	localparam logic [3:0] EXC_TLB_INV   = 4'h3;
	localparam logic [3:0] EXC_ADDR_ERR  = 4'h4;
	localparam logic [3:0] EXC_CACHE_ERR = 4'h5;
	localparam logic [3:0] EXC_BUS_ERR   = 4'h6;

	// Cause code attached to translation and address faults
	localparam logic [1:0] CAUSE_NONE           = 2'h0;
	localparam logic [1:0] tlb_load_cause       = 2'h1;
	localparam logic [1:0] tlb_store_cause      = 2'h2;
	localparam logic [1:0] addr_fault_load_cause= 2'h3;

	typedef struct packed {
		logic [XLEN-1:0] vaddr;
		logic            user_map;
		logic            load_ref;
	} cmo_xlat_req_t;

	typedef struct packed {
		logic [XLEN-1:0] paddr;
		logic            uncached;
		logic            refill;
		logic            invalid;
		logic            addr_err;
	} cmo_xlat_rsp_t;

	typedef struct packed {
		logic [1:0]      csel;
		logic [2:0]      op;
		logic [XLEN-1:0] addr;
		logic            by_index;
	} cmo_cache_req_t;

	typedef struct packed {
		logic [3:0] code;
		logic [1:0] cause;
	} cmo_exc_t;

	// Sign-extends the 9-bit offset and adds the base register
	function automatic logic [XLEN-1:0] eff_addr(input logic [XLEN-1:0] base,
			input logic [OFFS_W-1:0] offs);
		eff_addr = base + {{(XLEN-OFFS_W){offs[OFFS_W-1]}}, offs};
	endfunction : eff_addr

endpackage : cmo_pkg

// ===== rtl/cmo_unit.sv
// Cache maintenance unit for the user-mapped cache operation instruction.
// Assumes the pipeline holds the instruction until done, and that MMU, cache
// and bus answers arrive as single-cycle pulses from logic on the same clock.
`timescale 1ns/1ps

// Function
// [R1] Unimplemented operation/cache combination completes as a no-op.
// [R2] Address operation hitting an uncacheable address is a no-op.
// [R3] Coprocessor-unusable exception, no operation, when system coprocessor disabled.
// [R4] Any byte alignment accepted; never an alignment address error.
// [R5] Effective address is base register plus sign-extended 9-bit offset.
// [R6] Virtual cache address ops use effective address; optional translation faults.
// [R7] Physical cache address ops use MMU-translated physical address.
// [R8] Index ops still translate; index with effective or physical address.
// [R9] Index and way fields extracted from address; direct-mapped ignores way.
// [R10] Only load-cause TLB refill/invalid; never modified, store, inhibit faults.
// [R11] Writeback cache or bus error reports a cache-error exception.
// [R12] Bus transaction error response raises a bus-error exception; code suppresses it for index load tag and store tag.
// [R13] Cache-error exceptions suppressed for index load tag and store tag.
// [R14] Optional load-cause address error for faulting kernel regions.
// [R15] Bits [17:16] select instruction, data, tertiary or secondary cache.
// [R16] Bits [20:18] decode the operation code.
// [R17] Instruction and its transactions obey memory-barrier ordering rules.
// [R18] Translation uses the user-mode mapping even in kernel mode.
// [R19] Software should follow writebacks with a memory barrier.
// [R20] Software should OR index values into the unmapped kernel segment.
// [R21] Software must not lock every way at one index.
// [R22] Offset field is 9 bits in this release.
// [R23] Instruction exists only when enhanced virtual addressing enable reads 1.
// [R24] Any address-stage exception abandons the operation before cache changes.
module cmo_unit #(
	parameter int          CACHE_BYTES   = 16384,
	parameter int          ASSOC         = 4,
	parameter int          BYTES_PER_TAG = 32,
	parameter logic [3:0]  IMPL_MASK_I   = 4'h7,
	parameter logic [7:0]  OPS_PRI_I     = 8'h97,
	parameter logic [7:0]  OPS_PRI_D     = 8'hf7,
	parameter logic [7:0]  OPS_SEC       = 8'h77,
	parameter logic [7:0]  OPS_TER       = 8'h00,
	parameter bit          D_VIRTUAL     = 1'b1,
	parameter bit          KSEG_ADDR_ERR = 1'b0
) (
	// Clock and reset
	input  wire logic                   ref_clk_in,
	input  wire logic                   sys_rst_in,
	// Instruction issue
	input  wire logic                   issue_in,
	input  wire logic [31:0]            instr_word_in,
	input  wire logic [31:0]            base_val_in,
	input  wire logic                   cp0_usable_in,
	input  wire logic                   enhanced_virtual_addressing_enable_in,
	output logic                        done_out,
	output cmo_pkg::cmo_exc_t           exc_out,
	output logic                        reserved_instr_out,
	// Translation
	output logic                        xlat_valid_out,
	output cmo_pkg::cmo_xlat_req_t      xlat_req_out,
	input  wire logic                   xlat_done_in,
	input  wire cmo_pkg::cmo_xlat_rsp_t xlat_rsp_in,
	// Cache side
	output logic                        cache_valid_out,
	output cmo_pkg::cmo_cache_req_t     cache_req_out,
	output logic [15:0]                 cache_index_out,
	output logic [7:0]                  cache_way_out,
	input  wire logic                   cache_done_in,
	input  wire logic                   wb_err_in,
	input  wire logic                   bus_err_in,
	// Ordering
	output logic                        sync_req_out,
	input  wire logic                   sync_done_in
);

	localparam int OFFSET_BIT = $clog2(BYTES_PER_TAG);
	localparam int INDEX_BIT  = $clog2(CACHE_BYTES / ASSOC);
	localparam int WAY_W      = (ASSOC > 1) ? $clog2(ASSOC) : 1;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_XLAT  = 5'h02,
		ST_CACHE = 5'h04,
		ST_SYNC  = 5'h08,
		ST_DONE  = 5'h10
	} cmo_state_t;

	cmo_state_t             state;
	cmo_state_t             next_state;
	logic [31:0]            vaddr;
	logic [1:0]             csel;
	logic [2:0]             op;
	cmo_pkg::cmo_exc_t      exc;
	cmo_pkg::cmo_exc_t      next_exc;
	logic                   xlat_valid;
	logic                   cache_valid;
	logic                   sync_req;
	logic                   done;
	logic                   rsvd;
	logic                   rsvd_q;
	cmo_pkg::cmo_cache_req_t cache_req;
	logic [15:0]            cache_index;
	logic [7:0]             cache_way;

	// Instruction field decode
	wire  [8:0]  offs_f    = instr_word_in[cmo_pkg::OFFS_LSB +: cmo_pkg::OFFS_W]; // [R22]
	wire  [1:0]  csel_f    = instr_word_in[cmo_pkg::CSEL_LSB +: 2]; // [R15]
	wire  [2:0]  op_f      = instr_word_in[cmo_pkg::OP_LSB +: 3]; // [R16]
	wire  [31:0] ea_f      = cmo_pkg::eff_addr(base_val_in, offs_f); // [R5]
	wire  [7:0]  ops_sel   = (csel_f == cmo_pkg::CSEL_PRI_I) ? OPS_PRI_I :
	                         (csel_f == cmo_pkg::CSEL_PRI_D) ? OPS_PRI_D :
	                         (csel_f == cmo_pkg::CSEL_SEC)   ? OPS_SEC : OPS_TER;
	wire         op_impl   = ops_sel[op_f]; // [R1]
	wire         eva_ok    = enhanced_virtual_addressing_enable_in == 1'(cmo_pkg::EVA_ON); // [R23]
	wire         by_index  = ~op[2]; // Codes 0-3 are index type
	wire         diag_tag  = (op == cmo_pkg::OP_IDX_LD_TAG) || (op == cmo_pkg::OP_IDX_ST_TAG);
	wire         virt_c    = D_VIRTUAL && (csel == cmo_pkg::CSEL_PRI_I || csel == cmo_pkg::CSEL_PRI_D);
	// Only refill and invalid are taken from the MMU; other fault kinds cannot arise here
	wire         tlb_fault = xlat_rsp_in.refill | xlat_rsp_in.invalid; // [R10]
	wire         adr_fault = KSEG_ADDR_ERR && xlat_rsp_in.addr_err; // [R14] [R4]
	// Index ops use the untranslated address so software index values stay intact
	wire  [31:0] use_addr  = (by_index || virt_c) ? vaddr : xlat_rsp_in.paddr; // [R6] [R7] [R8]
	wire  [15:0] idx_w     = 16'((use_addr[INDEX_BIT-1:0]) >> OFFSET_BIT); // [R9]
	wire  [7:0]  way_w     = (ASSOC > 1) ? 8'(use_addr[INDEX_BIT +: WAY_W]) : 8'h00; // [R9]
	wire         err_seen  = wb_err_in | bus_err_in;

	// Exception selection for the translation and cache stages
	always_comb begin
		next_exc = exc;
		if (state == ST_XLAT && xlat_done_in) begin
			if (adr_fault) begin
				next_exc.code  = cmo_pkg::EXC_ADDR_ERR; // [R14]
				next_exc.cause = cmo_pkg::addr_fault_load_cause;
			end else if (xlat_rsp_in.refill) begin
				next_exc.code  = cmo_pkg::EXC_TLB_REFILL; // [R10]
				next_exc.cause = cmo_pkg::tlb_load_cause;
			end else if (xlat_rsp_in.invalid) begin
				next_exc.code  = cmo_pkg::EXC_TLB_INV; // [R10]
				next_exc.cause = cmo_pkg::tlb_load_cause;
			end
		end else if (state == ST_CACHE && err_seen && !diag_tag) begin // [R13]
			// Writeback failures surface as cache errors; plain bus errors stay bus errors
			next_exc.code  = wb_err_in ? cmo_pkg::EXC_CACHE_ERR : cmo_pkg::EXC_BUS_ERR; // [R11] [R12]
			next_exc.cause = cmo_pkg::CAUSE_NONE;
		end
	end

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (issue_in) begin
					if (!eva_ok || !cp0_usable_in || !op_impl) begin
						next_state = ST_DONE; // [R1] [R3] [R23]
					end else begin
						next_state = ST_XLAT;
					end
				end
			end
			ST_XLAT: begin
				if (xlat_done_in) begin
					if (tlb_fault || adr_fault) begin
						next_state = ST_DONE; // [R24]
					end else if (!by_index && xlat_rsp_in.uncached) begin
						next_state = ST_DONE; // [R2]
					end else begin
						next_state = ST_CACHE;
					end
				end
			end
			ST_CACHE: begin
				if (cache_done_in) begin
					next_state = ST_SYNC; // [R17]
				end
			end
			ST_SYNC: begin
				if (sync_done_in) begin
					next_state = ST_DONE;
				end
			end
			ST_DONE: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			state <= ST_IDLE;
			exc   <= '0;
		end else begin
			state <= next_state;
			exc   <= (state == ST_IDLE) ? cmo_pkg::cmo_exc_t'(0) : next_exc;
		end
	end

	// Captured instruction fields
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			vaddr <= '0;
			csel  <= '0;
			op    <= '0;
			rsvd  <= 1'b0;
		end else if (state == ST_IDLE && issue_in) begin
			vaddr <= ea_f;
			csel  <= csel_f;
			op    <= op_f;
			rsvd  <= !eva_ok; // [R23]
		end
	end

	// Coprocessor check is taken at issue so no cache request is ever made
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			exc_out <= '0;
		end else if (state == ST_IDLE && issue_in && eva_ok && !cp0_usable_in) begin
			exc_out <= '{code: cmo_pkg::EXC_CPU, cause: cmo_pkg::CAUSE_NONE}; // [R3]
		end else if (state == ST_IDLE && issue_in) begin
			exc_out <= '0;
		end else if (next_state == ST_DONE && state != ST_IDLE) begin
			exc_out <= next_exc;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			xlat_valid  <= 1'b0;
			cache_valid <= 1'b0;
			sync_req    <= 1'b0;
			done        <= 1'b0;
			rsvd_q      <= 1'b0;
			cache_req   <= '0;
			cache_index <= '0;
			cache_way   <= '0;
		end else begin
			xlat_valid  <= (next_state == ST_XLAT) && (state != ST_XLAT);
			cache_valid <= (next_state == ST_CACHE) && (state != ST_CACHE); // [R24]
			sync_req    <= (next_state == ST_SYNC) && (state != ST_SYNC); // [R17]
			done        <= (next_state == ST_DONE);
			// Registered so the flag leaves on a flop, aligned with done
			rsvd_q      <= (next_state == ST_DONE) && ((state == ST_IDLE) ? !eva_ok : rsvd); // [R23]
			if (state == ST_XLAT && xlat_done_in) begin
				cache_req   <= '{csel: csel, op: op, addr: use_addr, by_index: by_index};
				cache_index <= idx_w;
				cache_way   <= way_w;
			end
		end
	end

	assign xlat_valid_out     = xlat_valid;
	// User mapping and load reference are fixed for this instruction
	assign xlat_req_out       = '{vaddr: vaddr, user_map: 1'b1, load_ref: 1'b1}; // [R18]
	assign cache_valid_out    = cache_valid;
	assign cache_req_out      = cache_req;
	assign cache_index_out    = cache_index;
	assign cache_way_out      = cache_way;
	assign sync_req_out       = sync_req;
	assign done_out           = done;
	assign reserved_instr_out = rsvd_q;

endmodule : cmo_unit

// ===== sim/cmo_unit_asserts.sv
// Port-level checker for the cache maintenance unit.
// Assumes the pipeline issues only while the unit is idle.
`timescale 1ns/1ps
module cmo_unit_asserts #(
	parameter int CACHE_BYTES   = 16384,
	parameter int ASSOC         = 4,
	parameter int BYTES_PER_TAG = 32
) (
	// Pipeline side
	input logic                    ref_clk_in,
	input logic                    sys_rst_in,
	input logic                    issue_in,
	input logic [31:0]             instr_word_in,
	input logic [31:0]             base_val_in,
	input logic                    cp0_usable_in,
	input logic                    enhanced_virtual_addressing_enable_in,
	input logic                    done_out,
	input cmo_pkg::cmo_exc_t       exc_out,
	input logic                    reserved_instr_out,
	// Far side
	input logic                    xlat_valid_out,
	input cmo_pkg::cmo_xlat_req_t  xlat_req_out,
	input logic                    xlat_done_in,
	input cmo_pkg::cmo_xlat_rsp_t  xlat_rsp_in,
	input logic                    cache_valid_out,
	input cmo_pkg::cmo_cache_req_t cache_req_out,
	input logic [15:0]             cache_index_out,
	input logic [7:0]              cache_way_out,
	input logic                    cache_done_in,
	input logic                    sync_req_out
);
	localparam int OB = $clog2(BYTES_PER_TAG);
	localparam int IB = $clog2(CACHE_BYTES / ASSOC);
	logic [31:0] ea_q;
	logic [4:0]  co_q;
	wire         ok_in = cp0_usable_in && enhanced_virtual_addressing_enable_in;
	always_ff @(posedge ref_clk_in) begin
		if (issue_in) begin
			ea_q <= base_val_in + {{23{instr_word_in[15]}}, instr_word_in[15:7]};
			co_q <= instr_word_in[20:16];
		end
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_fault;
		xlat_done_in && (xlat_rsp_in.refill || xlat_rsp_in.invalid) && !xlat_rsp_in.addr_err;
	endsequence
	sequence s_fault_end;
		done_out && exc_out.cause == cmo_pkg::tlb_load_cause;
	endsequence
	property p_cpu; issue_in && !cp0_usable_in && enhanced_virtual_addressing_enable_in
		|=> done_out && exc_out.code == cmo_pkg::EXC_CPU; endproperty
	a_cpu: assert property (p_cpu) else $error("no unusable fault");
	property p_rsv; issue_in && !enhanced_virtual_addressing_enable_in |=> done_out && reserved_instr_out; endproperty
	a_rsv: assert property (p_rsv) else $error("no reserved answer");
	property p_noxl; issue_in && !ok_in |=> !xlat_valid_out [*2]; endproperty
	a_noxl: assert property (p_noxl) else $error("refused op translated");
	property p_xreq; xlat_valid_out |-> xlat_req_out.user_map && xlat_req_out.load_ref && xlat_req_out.vaddr == ea_q;
	endproperty
	a_xreq: assert property (p_xreq) else $error("bad translation request");
	property p_cq; cache_valid_out |-> {cache_req_out.op, cache_req_out.csel} == co_q
		&& cache_req_out.by_index == !co_q[4]; endproperty
	a_cq: assert property (p_cq) else $error("bad cache decode");
	property p_idx; cache_valid_out |-> cache_index_out == 16'((cache_req_out.addr >> OB) & ((32'h1 << (IB - OB)) - 1))
		&& cache_way_out == 8'((cache_req_out.addr >> IB) & (ASSOC - 1)); endproperty
	a_idx: assert property (p_idx) else $error("bad index or way");
	property p_fault; s_fault |-> !cache_valid_out ##[0:1] s_fault_end; endproperty
	a_fault: assert property (p_fault) else $error("fault not reported");
	property p_sync; cache_done_in |=> sync_req_out; endproperty
	a_sync: assert property (p_sync) else $error("no barrier after cache op");
endmodule : cmo_unit_asserts

bind cmo_unit cmo_unit_asserts #(.CACHE_BYTES(CACHE_BYTES), .ASSOC(ASSOC), .BYTES_PER_TAG(BYTES_PER_TAG))
	cmo_unit_asserts_inst (.*);

// ===== sim/cmo_far_model.sv
// Far-side model: MMU, cache levels and barrier unit answering one request at a time.
// Assumes knobs {dly, flt, unc, wbe, bue} from the bench, dly of at least one.
`timescale 1ns/1ps
module cmo_far_model (
	// Clock, reset, knobs
	input  logic                   ref_clk_in,
	input  logic                   sys_rst_in,
	input  logic [6:0]             cfg_in,
	// Requests
	input  logic                   xlat_valid_in,
	input  cmo_pkg::cmo_xlat_req_t xlat_req_in,
	input  logic                   cache_valid_in,
	input  logic                   sync_req_in,
	// Answers
	output logic                   xlat_done_out,
	output cmo_pkg::cmo_xlat_rsp_t xlat_rsp_out,
	output logic                   cache_done_out,
	output logic                   wb_err_out,
	output logic                   bus_err_out,
	output logic                   sync_done_out
);
	logic [1:0]             st;
	logic [1:0]             cnt;
	cmo_pkg::cmo_xlat_rsp_t rsp;
	wire                    err_win = st == 2'h2 && cnt == 2'h1;
	// Inverted outside the answer so that stale response fields never pass
	assign xlat_rsp_out = xlat_done_out ? rsp : ~rsp;
	assign wb_err_out = err_win && cfg_in[1];
	assign bus_err_out = err_win && cfg_in[0];
	always_ff @(posedge ref_clk_in) begin
		xlat_done_out <= 1'b0;
		cache_done_out <= 1'b0;
		sync_done_out <= 1'b0;
		if (sys_rst_in) begin
			st <= 2'h0;
			rsp <= '0;
		end else if (st == 2'h0) begin
			cnt <= cfg_in[6:5];
			if (xlat_valid_in) begin
				st <= 2'h1;
				rsp <= {xlat_req_in.vaddr ^ 32'h40000000, cfg_in[2], cfg_in[4:3] == 2'h1, cfg_in[4:3] == 2'h2, 1'b0};
			end else if (cache_valid_in) st <= 2'h2;
			else if (sync_req_in) st <= 2'h3;
		end else if (cnt != 2'h0) cnt <= cnt - 2'h1;
		else begin
			st <= 2'h0;
			xlat_done_out <= st == 2'h1;
			cache_done_out <= st == 2'h2;
			sync_done_out <= st == 2'h3;
		end
	end
endmodule : cmo_far_model

// ===== sim/tb_cmo_unit.sv
// Self-checking bench: pipeline driver, far-side model, expectation functions.
// Assumes the unit's default geometry, virtual primaries and operation masks.
`timescale 1ns/1ps
module tb_cmo_unit;
	localparam logic [31:0] OPS = 32'h7700f797; // Masks for S, T, D, I
	logic clk = 0, rst = 1, iss = 0, cp = 1, ev = 1, dn, rsv, xv, xd, cv, cd, we, be, sq, sd;
	logic [31:0] ins = 0, bas = 0, va, ca;
	logic [6:0] cfg = 7'h20;
	cmo_pkg::cmo_exc_t exc;
	cmo_pkg::cmo_xlat_req_t xq;
	cmo_pkg::cmo_xlat_rsp_t xr;
	cmo_pkg::cmo_cache_req_t cq;
	int error_cnt = 0, cmp_count = 0, nx, nc;
	always #4 clk = ~clk;
	cmo_unit cmo_unit_inst (.ref_clk_in(clk), .sys_rst_in(rst), .issue_in(iss), .instr_word_in(ins),
		.base_val_in(bas), .cp0_usable_in(cp), .enhanced_virtual_addressing_enable_in(ev), .done_out(dn),
		.exc_out(exc), .reserved_instr_out(rsv), .xlat_valid_out(xv), .xlat_req_out(xq), .xlat_done_in(xd),
		.xlat_rsp_in(xr), .cache_valid_out(cv), .cache_req_out(cq), .cache_index_out(), .cache_way_out(),
		.cache_done_in(cd), .wb_err_in(we), .bus_err_in(be), .sync_req_out(sq), .sync_done_in(sd));
	cmo_far_model cmo_far_model_inst (.ref_clk_in(clk), .sys_rst_in(rst), .cfg_in(cfg), .xlat_valid_in(xv),
		.xlat_req_in(xq), .cache_valid_in(cv), .sync_req_in(sq), .xlat_done_out(xd), .xlat_rsp_out(xr),
		.cache_done_out(cd), .wb_err_out(we), .bus_err_out(be), .sync_done_out(sd));
	always @(negedge clk) begin
		if (xv) begin nx++; va = xq.vaddr; end
		if (cv) begin nc++; ca = cq.addr; end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask : chk
	function automatic logic [5:0] exp_exc(input logic [1:0] c, input logic [2:0] o);
		if (!cp) return {cmo_pkg::EXC_CPU, cmo_pkg::CAUSE_NONE};
		if (!OPS[{c, o}]) return 6'h00;
		// Translation faults are not suppressed for the tag diagnostics
		if (cfg[4:3] != 0) return {cfg[3] ? cmo_pkg::EXC_TLB_REFILL : cmo_pkg::EXC_TLB_INV, cmo_pkg::tlb_load_cause};
		if ((cfg[2] && o[2]) || o == 3'h1 || o == 3'h2) return 6'h00;
		if (cfg[1]) return {cmo_pkg::EXC_CACHE_ERR, cmo_pkg::CAUSE_NONE};
		return cfg[0] ? {cmo_pkg::EXC_BUS_ERR, cmo_pkg::CAUSE_NONE} : 6'h00;
	endfunction : exp_exc
	task automatic run(input logic [1:0] c, input logic [2:0] o, input logic [31:0] b, input logic [8:0] f,
			input logic p, input logic v);
		logic [31:0] ea;
		int n;
		ea = b + {{23{f[8]}}, f};
		@(posedge clk);
		iss <= 1'b1;
		ins <= {11'h0, o, c, f, 7'h0};
		bas <= b;
		cp <= p;
		ev <= v;
		cfg <= {2'($urandom % 3 + 1), ($urandom % 4 == 0) ? 2'($urandom % 2 + 1) : 2'h0, 3'($urandom)};
		nx = 0;
		nc = 0;
		@(posedge clk);
		iss <= 1'b0;
		n = 0;
		do begin @(negedge clk); n++; end while (dn !== 1'b1 && n < 300);
		chk(dn, 1);
		chk(rsv, !v);
		if (!v) begin chk(nx + nc, 0); return; end
		chk(exc, exp_exc(c, o));
		chk(nx, p && OPS[{c, o}]);
		chk(nc, p && OPS[{c, o}] && cfg[4:3] == 0 && !(cfg[2] && o[2]));
		if (nx != 0) chk(va, ea);
		if (nc != 0) chk(ca, (!o[2] || !c[1]) ? ea : ea ^ 32'h40000000);
	endtask : run
	task automatic summarize();
		$display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize
	initial begin
		void'($urandom(32'h85de22c7));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk({dn, xv, cv, sq}, 0);
		$display("test reset done");
		for (int i = 0; i < 32; i++) run(2'(i / 8), 3'(i), $urandom, 9'($urandom), 1'b1, 1'b1);
		run(2'h1, 3'h6, 32'h00000000, 9'h100, 1'b1, 1'b1);
		run(2'h3, 3'h5, 32'hffffffff, 9'h0ff, 1'b1, 1'b1);
		run(2'h1, 3'h4, $urandom, 9'h003, 1'b0, 1'b1);
		run(2'h0, 3'h0, $urandom, 9'h001, 1'b1, 1'b0);
		run(2'h1, 3'h2, 32'h80000000 | 32'($urandom % 4096), 9'h000, 1'b1, 1'b1);
		$display("test sweep done");
		// Random bases make locking every way of one index practically impossible
		repeat (60) run(2'($urandom), 3'($urandom), $urandom, 9'($urandom), $urandom % 4 != 0, $urandom % 8 != 0);
		$display("test random done");
		summarize();
	end
	// Runs take some 20 cycles each; this span is ten times the whole suite
	initial begin
		#200000;
		error_cnt++;
		summarize();
	end
endmodule : tb_cmo_unit
